// [logic/trig_port_pkg.sv]
// How it works
// RULE1: Value register bits 7..0 hold port levels; 31..8 read as zero.
// RULE2: Port bits 7..5 always follow the value register directly.
// RULE3: Port bit 4 shows value bit 4, or the combined trigger if selected.
// RULE4: Port bits 3..0 show value bits, or their channel trigger if selected.
// RULE5: The trigger pulse width for bits 3..0 comes from setup bits 31..29.
// RULE6: One width setting applies to every one of bits 3..0 configured as a trigger output.
// RULE7: Codes 000 to 011 give 1 ms, 200 us, 20 us, 5 us; codes 1xx toggle.
// RULE8: Setup bits 28..5 are reserved, read as zero and have no effect.
// RULE9: Toggle flips the bit per event; a pulse stays high for the width.
package trig_port_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_VALUE = 8'h00;
  localparam logic [7:0] ADDR_SETUP = 8'h04;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 5;
  localparam int WIDTH_LSB = 29;
  localparam int WIDTH_W = 3;
  localparam int TOGGLE_BIT = 2;
  localparam int CNT_W = 18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Times in ns, cycle counts derived from the 4 ns clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_1MS_NS = 1000000;
  localparam int T_200US_NS = 200000;
  localparam int T_20US_NS = 20000;
  localparam int T_5US_NS = 5000;
  localparam int CYC_1MS = T_1MS_NS / CLK_PERIOD_NS;
  localparam int CYC_200US = T_200US_NS / CLK_PERIOD_NS;
  localparam int CYC_20US = T_20US_NS / CLK_PERIOD_NS;
  localparam int CYC_5US = T_5US_NS / CLK_PERIOD_NS;
  localparam logic [7:0] VALUE_RST = 8'h00;
  localparam logic [4:0] SEL_RST = 5'h00;
  localparam logic [2:0] WIDTH_RST = 3'h0;
endpackage : trig_port_pkg

// [logic/trigger_output_port_mux.sv]
`timescale 1ns/1ps
module trigger_output_port_mux #(
  parameter logic [17:0] CYC_1MS = 18'(trig_port_pkg::CYC_1MS),
  parameter logic [17:0] CYC_200US = 18'(trig_port_pkg::CYC_200US),
  parameter logic [17:0] CYC_20US = 18'(trig_port_pkg::CYC_20US),
  parameter logic [17:0] CYC_5US = 18'(trig_port_pkg::CYC_5US)
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic [3:0] CHANNEL_TRIGGER_OUTPUT,
  input wire logic COMBINED_TRIG,
  output logic [7:0] PORT_OUT
);

  typedef struct packed {
    logic [7:0] port_value_reg;
    logic [4:0] sel;
    logic [2:0] width;
    logic [3:0][17:0] cnt;
    logic [3:0] tog;
    logic [7:0] port;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  localparam state_t STATE_RST = '{
    port_value_reg: trig_port_pkg::VALUE_RST,
    sel: trig_port_pkg::SEL_RST,
    width: trig_port_pkg::WIDTH_RST,
    default: '0
  };

  state_t s;
  state_t next_s;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;

  // Pulse length for a width code; toggle codes never load the counter
  function automatic logic [17:0] width_cycles(input logic [2:0] w);
    case (w[1:0])
      2'h0: width_cycles = CYC_1MS;
      2'h1: width_cycles = CYC_200US;
      2'h2: width_cycles = CYC_20US;
      default: width_cycles = CYC_5US;
    endcase
  endfunction : width_cycles

  // Only the two word addresses are mapped
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == trig_port_pkg::ADDR_VALUE) ||
      (a == trig_port_pkg::ADDR_SETUP);
  endfunction : addr_hit

  // Readies drop while a write answer waits, so one write is in flight
  assign AWREADY = !s.aw_got && !s.bvalid;
  assign WREADY = !s.w_got && !s.bvalid;
  assign ARREADY = !s.rvalid;
  assign aw_hs = AWVALID && AWREADY;
  assign w_hs = WVALID && WREADY;
  assign ar_hs = ARVALID && ARREADY;
  assign BVALID = s.bvalid;
  assign BRESP = s.bresp;
  assign RVALID = s.rvalid;
  assign RDATA = s.rdata;
  assign RRESP = s.rresp;
  assign PORT_OUT = s.port;

  // Next state: bus slave, trigger shapers and port mux
  always_comb begin
    next_s = s;
    if (aw_hs) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = AWADDR;
    end
    if (w_hs) begin
      next_s.w_got = 1'b1;
      next_s.wdata = WDATA;
      next_s.wstrb = WSTRB;
    end
    if (next_s.aw_got && next_s.w_got) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = addr_hit(next_s.awaddr) ? trig_port_pkg::RESP_OKAY :
        trig_port_pkg::RESP_SLVERR;
      case (next_s.awaddr)
        trig_port_pkg::ADDR_VALUE: begin
          if (next_s.wstrb[0]) begin
            next_s.port_value_reg = next_s.wdata[7:0]; // RULE1
          end
        end
        trig_port_pkg::ADDR_SETUP: begin
          // Reserved bits are simply not stored
          if (next_s.wstrb[0]) begin
            next_s.sel = next_s.wdata[4:0]; // RULE8
          end
          if (next_s.wstrb[3]) begin
            next_s.width = next_s.wdata[31:29]; // RULE5
          end
        end
        default: begin
        end
      endcase
    end else if (s.bvalid && BREADY) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && RREADY) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_hs) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = addr_hit(ARADDR) ? trig_port_pkg::RESP_OKAY :
        trig_port_pkg::RESP_SLVERR;
      case (ARADDR)
        trig_port_pkg::ADDR_VALUE:
          next_s.rdata = {24'h000000, s.port_value_reg}; // RULE1
        trig_port_pkg::ADDR_SETUP:
          next_s.rdata = {s.width, 24'h000000, s.sel}; // RULE8
        default: next_s.rdata = 32'h00000000;
      endcase
    end
    // A new event restarts the pulse, so bursts stretch the output
    for (int i = 0; i < 4; i++) begin
      if (s.cnt[i] != 18'h00000) begin
        next_s.cnt[i] = s.cnt[i] - 18'h00001; // RULE9
      end
      if (CHANNEL_TRIGGER_OUTPUT[i]) begin
        if (s.width[trig_port_pkg::TOGGLE_BIT]) begin
          next_s.tog[i] = ~s.tog[i]; // RULE9
        end else begin
          next_s.cnt[i] = width_cycles(s.width); // RULE6 RULE7
        end
      end
      next_s.port[i] = !s.sel[i] ? s.port_value_reg[i] : // RULE4
        s.width[trig_port_pkg::TOGGLE_BIT] ? s.tog[i] : // RULE7
        (s.cnt[i] != 18'h00000);
    end
    next_s.port[4] = s.sel[4] ? COMBINED_TRIG : s.port_value_reg[4]; // RULE3
    next_s.port[7:5] = s.port_value_reg[7:5]; // RULE2
  end

  // Single state register with synchronous reset
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  property p_value_read;
    ar_hs && ARADDR == trig_port_pkg::ADDR_VALUE |=>
      RVALID && RDATA == {24'h000000, $past(s.port_value_reg)};
  endproperty
  a_value_read: assert property (p_value_read) // RULE1
    else $error("Value register read wrong");

  property p_upper_bits;
    ##1 PORT_OUT[7:5] == $past(s.port_value_reg[7:5]);
  endproperty
  a_upper_bits: assert property (p_upper_bits) // RULE2
    else $error("Upper port bits not from value register");

  property p_bit4;
    s.sel[4] |=> PORT_OUT[4] == $past(COMBINED_TRIG);
  endproperty
  a_bit4: assert property (p_bit4) // RULE3
    else $error("Port bit 4 not combined trigger");

  property p_bit0_plain;
    !s.sel[0] |=> PORT_OUT[0] == $past(s.port_value_reg[0]);
  endproperty
  a_bit0_plain: assert property (p_bit0_plain) // RULE4
    else $error("Port bit 0 not from value register");

  property p_width_load;
    CHANNEL_TRIGGER_OUTPUT[1] && !s.width[2] |=>
      s.cnt[1] == width_cycles($past(s.width));
  endproperty
  a_width_load: assert property (p_width_load) // RULE5
    else $error("Pulse width not taken from width field");

  property p_same_width;
    CHANNEL_TRIGGER_OUTPUT[0] && CHANNEL_TRIGGER_OUTPUT[3] && !s.width[2]
      |=> s.cnt[0] == s.cnt[3];
  endproperty
  a_same_width: assert property (p_same_width) // RULE6
    else $error("Channels got different widths");

  property p_toggle;
    // Mode and select must still stand when the new level is launched
    s.sel[2] && s.width[2] && CHANNEL_TRIGGER_OUTPUT[2] &&
      !s.bvalid ##1 (s.width[2] && s.sel[2]) |->
      ##1 PORT_OUT[2] != $past(PORT_OUT[2]);
  endproperty
  a_toggle: assert property (p_toggle) // RULE7
    else $error("Toggle mode did not invert");

  property p_setup_reserved;
    ar_hs && ARADDR == trig_port_pkg::ADDR_SETUP |=> RDATA[28:5] == 24'h0;
  endproperty
  a_setup_reserved: assert property (p_setup_reserved) // RULE8
    else $error("Reserved setup bits not zero");

  property p_pulse_high;
    s.sel[3] && !s.width[2] && s.cnt[3] != 18'h0 |=> PORT_OUT[3];
  endproperty
  a_pulse_high: assert property (p_pulse_high) // RULE9
    else $error("Pulse output low while counting");

  c_write: cover property (BVALID && BREADY && BRESP == 2'h0);
  c_pulse: cover property (s.sel[0] && CHANNEL_TRIGGER_OUTPUT[0]
    ##2 PORT_OUT[0]);
  c_toggle: cover property (s.width[2] && CHANNEL_TRIGGER_OUTPUT[1]);
endmodule : trigger_output_port_mux

// [tb/port_observer.sv]
`timescale 1ns/1ps
module port_observer (
  input wire logic clk,
  input wire logic [3:0] level,
  output int high_len [4]
);
  int run [4] = '{default: 0};
  // Time each high stretch on the trigger bits; latched when it ends
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (level[i] === 1'b1) begin
        run[i] <= run[i] + 1;
      end else begin
        if (run[i] != 0) high_len[i] <= run[i];
        run[i] <= 0;
      end
    end
  end
endmodule : port_observer

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [7:0] a; logic [31:0] d, rd; logic [1:0] rs;
    logic [7:0] p;} row_t;
  logic CLK_SYS = 0, RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0;
  logic ARVALID = 0, RREADY = 0, COMBINED_TRIG = 0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [7:0] AWADDR = 0, ARADDR = 0, PORT_OUT;
  logic [31:0] WDATA = 0, RDATA;
  logic [3:0] WSTRB = 4'hf, CHANNEL_TRIGGER_OUTPUT = 0;
  logic [1:0] BRESP, RRESP, br, rr;
  logic [31:0] rd;
  logic old;
  int errors = 0, comparisons = 0, hl [4];
  int wid [4] = '{32'h28, 32'h14, 32'h0a, 32'h05};
  // Ordinary accesses: address, data, read-back, response, port level
  row_t rows [5] = '{
    '{8'h00, 32'hffffffff, 32'h000000ff, 2'h0, 8'hff},
    '{8'h04, 32'hffffffff, 32'he000001f, 2'h0, 8'he0},
    '{8'h08, 32'h12345678, 32'h00000000, 2'h2, 8'he0},
    '{8'h00, 32'h000000a5, 32'h000000a5, 2'h0, 8'ha0},
    '{8'h04, 32'h00000000, 32'h00000000, 2'h0, 8'ha5}};
  // Short pulse counts keep the run small; wid holds the same numbers
  trigger_output_port_mux #(.CYC_1MS(18'h28), .CYC_200US(18'h14),
    .CYC_20US(18'h0a), .CYC_5US(18'h05)) trigger_output_port_mux_inst (
    .CLK_SYS(CLK_SYS), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .CHANNEL_TRIGGER_OUTPUT(CHANNEL_TRIGGER_OUTPUT),
    .COMBINED_TRIG(COMBINED_TRIG), .PORT_OUT(PORT_OUT));
  port_observer port_observer_inst (.clk(CLK_SYS), .level(PORT_OUT[3:0]),
    .high_len(hl));
  // 250 MHz system clock
  always #2 CLK_SYS = ~CLK_SYS;
  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // Both write halves offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    br = BRESP;
    BREADY <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    rd = RDATA;
    rr = RRESP;
    RREADY <= 1'b0;
  endtask : rdr
  task automatic trig(input logic [3:0] m);
    @(posedge CLK_SYS);
    CHANNEL_TRIGGER_OUTPUT <= m;
    @(posedge CLK_SYS);
    CHANNEL_TRIGGER_OUTPUT <= 4'h0;
    repeat (50) @(posedge CLK_SYS);
  endtask : trig
  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  // Watchdog: the whole run needs well under 3000 cycles
  initial begin
    #100000;
    errors++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge CLK_SYS);
    RST <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk("bresp", br, rows[i].rs);
      rdr(rows[i].a);
      chk("rdata", rd, rows[i].rd);
      chk("rresp", rr, rows[i].rs);
      repeat (3) @(posedge CLK_SYS);
      chk("port", PORT_OUT, rows[i].p);
    end
    // Combined trigger onto bit 4, value bit 4 is low
    wr(8'h04, 32'h00000010);
    COMBINED_TRIG <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    chk("combined", PORT_OUT, 8'hb5);
    COMBINED_TRIG <= 1'b0;
    // Every pulse code, all four channels fired together
    for (int c = 0; c < 4; c++) begin
      wr(8'h04, {3'(c), 29'h0000000f});
      trig(4'hf);
      for (int i = 0; i < 4; i++) begin
        chk("width", hl[i], wid[c]);
      end
    end
    // Every toggle code flips bit 0 once per event; bit 2 fires as well
    for (int c = 4; c < 8; c++) begin
      wr(8'h04, {3'(c), 29'h0000000f});
      repeat (3) @(posedge CLK_SYS);
      old = PORT_OUT[0];
      trig(4'h5);
      chk("toggle", PORT_OUT[0], !old);
    end
    // Reset in mid-run clears port and registers
    RST <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    chk("rst port", PORT_OUT, 8'h00);
    RST <= 1'b0;
    rdr(8'h00);
    chk("rst value", rd, 32'h0);
    // Let an edge pass so RREADY is not driven twice in one step
    @(posedge CLK_SYS);
    rdr(8'h04);
    chk("rst setup", rd, 32'h0);
    summarize();
  end
endmodule : tb_top
